// ---- core/align_logic_branch_exec_map.vh ----
// Encodings and field positions for the align, AND and branch decoder
`ifndef ALIGN_LOGIC_BRANCH_EXEC_MAP_VH
`define ALIGN_LOGIC_BRANCH_EXEC_MAP_VH
`define OPC_REGISTER_FUNCTION_CLASS 6'h00
`define OPC_REGISTER_IMMEDIATE_CLASS 6'h01
`define OPC_BRANCH_IF_EQUAL 6'h04
`define OPC_AND_IMMEDIATE 6'h0C
`define OPC_FP_COPROCESSOR 6'h11
`define OPC_FP_EXTENDED 6'h13
`define FUNC_AND 6'h24
`define FUNC_PAIRED_SINGLE_ALIGN 6'h1E
`define RT_BRANCH_GE_ZERO_LINK 5'h11
`define FMT_FP_BRANCH 5'h08
`define LINK_REG 5'h1F
`define ALIGN_SHIFT_NONE 3'h0
`define ALIGN_SHIFT_WORD 3'h4
`define OPC_MSB 31
`define OPC_LSB 26
`define RS_MSB 25
`define RS_LSB 21
`define RT_MSB 20
`define RT_LSB 16
`define RD_MSB 15
`define RD_LSB 11
`define SA_MSB 10
`define SA_LSB 6
`define FUNC_MSB 5
`define FUNC_LSB 0
`define CC_MSB 20
`define CC_LSB 18
`define ND_BIT 17
`define TF_BIT 16
`define INSN_STEP 32'h00000004
`define PC_RESET 32'h00000000
`endif

// ---- core/align_logic_branch_exec.v ----
// Decode and execute stage for align, AND, branch and FP condition branch
// Function
// - Decode align from extended FP opcode, function
// - Funnel-shift source pair by low three bits, for shift four only
// - Shift zero copies first FP source
// - Big-endian shift four swaps halves one way
// - Little-endian shift four swaps the other way
// - Align raises no FP arithmetic flags
// - Register AND of two sources to destination
// - AND-immediate zero-extends sixteen-bit immediate
// - Branch-if-equal with zero registers always taken
// - Target is delay slot plus shifted offset
// - PC loads target after delay slot
// - Branch-and-link idiom from register-immediate class
// - Link register gets second following address
// - Decode FP condition branch fields
// - Branch-on-false taken when condition bit zero
// - Sense and nullify flags share one datapath
// - Raise coprocessor-unusable or reserved-instruction exceptions
// - Not-taken nullify branch cancels delay slot
`timescale 1ns/100ps
`include "align_logic_branch_exec_map.vh"
module align_logic_branch_exec
#(
	parameter XLEN = 32,
	parameter FLEN = 64
)
(
	input wire clk_i,
	input wire reset_i,
	input wire insn_valid_i,
	input wire [31:0] insn_i,
	input wire [XLEN-1:0] gpr_source_i,
	input wire [XLEN-1:0] gpr_target_i,
	input wire [FLEN-1:0] fp_source_a_i,
	input wire [FLEN-1:0] fp_source_b_i,
	input wire [7:0] fp_condition_codes_i,
	input wire fp_usable_i,
	input wire fp_ps_enabled_i,
	input wire big_endian_i,
	output wire [4:0] gpr_source_sel_o,
	output wire [4:0] gpr_target_sel_o,
	output wire [4:0] fp_source_a_sel_o,
	output wire [4:0] fp_source_b_sel_o,
	output reg gpr_we_o,
	output reg [4:0] gpr_waddr_o,
	output reg [XLEN-1:0] gpr_wdata_o,
	output reg fpr_we_o,
	output reg [4:0] fpr_waddr_o,
	output reg [FLEN-1:0] fpr_wdata_o,
	output reg fp_flags_we_o,
	output reg [31:0] pc_o,
	output reg delay_slot_o,
	output reg nullified_o,
	output reg exc_cop_unusable_o,
	output reg exc_reserved_o,
	output reg exc_fp_unimpl_o,
	output reg decode_error_o
);

function [31:0] branch_offset;
	input [15:0] imm;
	begin
		branch_offset = {{14{imm[15]}}, imm, 2'b00};
	end
endfunction

// Upper word from one source, lower word from the other
function [63:0] join_words;
	input [63:0] upper_src;
	input [63:0] lower_src;
	begin
		join_words = {upper_src[31:0], lower_src[63:32]};
	end
endfunction

wire [5:0] opc = insn_i[`OPC_MSB:`OPC_LSB];
wire [4:0] f_rs = insn_i[`RS_MSB:`RS_LSB];
wire [4:0] f_rt = insn_i[`RT_MSB:`RT_LSB];
wire [4:0] f_rd = insn_i[`RD_MSB:`RD_LSB];
wire [4:0] f_sa = insn_i[`SA_MSB:`SA_LSB];
wire [5:0] f_func = insn_i[`FUNC_MSB:`FUNC_LSB];
wire [2:0] cc_sel = insn_i[`CC_MSB:`CC_LSB];
wire nd_flag = insn_i[`ND_BIT];
wire tf_flag = insn_i[`TF_BIT];
wire [15:0] imm16 = insn_i[15:0];

assign gpr_source_sel_o = f_rs;
assign gpr_target_sel_o = f_rt;
assign fp_source_a_sel_o = f_rd;
assign fp_source_b_sel_o = f_rt;

// Instruction class decode
wire is_align = (opc == `OPC_FP_EXTENDED) && (f_func == `FUNC_PAIRED_SINGLE_ALIGN);
wire is_and = (opc == `OPC_REGISTER_FUNCTION_CLASS) && (f_func == `FUNC_AND)
	&& (f_sa == 5'h00);
wire is_and_immediate = (opc == `OPC_AND_IMMEDIATE);
wire is_beq0 = (opc == `OPC_BRANCH_IF_EQUAL) && (f_rs == 5'h00) && (f_rt == 5'h00);
wire is_bal = (opc == `OPC_REGISTER_IMMEDIATE_CLASS) && (f_rt == `RT_BRANCH_GE_ZERO_LINK)
	&& (f_rs == 5'h00);
wire is_fpbr = (opc == `OPC_FP_COPROCESSOR) && (f_rs == `FMT_FP_BRANCH);
wire is_branch = is_beq0 || is_bal || is_fpbr;
wire is_fp = is_align || is_fpbr;

// One condition path for all four sense/nullify variants
wire [7:0] cc_hit;
genvar g;
generate
	for (g = 0; g < 8; g = g + 1)
	begin : g_cc
		localparam [2:0] CC_INDEX = g;
		assign cc_hit[g] = fp_condition_codes_i[g] && (cc_sel == CC_INDEX);
	end
endgenerate
wire fp_cond_bit = |cc_hit;
wire fp_taken = (fp_cond_bit == tf_flag);

// Align datapath: only 0 and 4 defined; other shifts reuse the zero path
wire [2:0] shift = gpr_source_i[2:0];
reg [FLEN-1:0] align_res;
always @*
begin
	if (shift == `ALIGN_SHIFT_WORD)
	begin
		if (big_endian_i)
			align_res = join_words(fp_source_a_i, fp_source_b_i);
		else
			align_res = join_words(fp_source_b_i, fp_source_a_i);
	end
	else
		align_res = fp_source_a_i;
end

// Sequencing state
localparam [1:0] ST_LINEAR = 2'b00;
localparam [1:0] ST_SLOT_FALL = 2'b01;
localparam [1:0] ST_SLOT_TAKE = 2'b10;
localparam [1:0] ST_SLOT_KILL = 2'b11;

reg [1:0] state_q;
reg [1:0] state_d;
reg [31:0] pc_q;
reg [31:0] pc_d;
reg [31:0] target_q;
reg [31:0] target_d;

// Slot status of the instruction now offered
wire in_slot = (state_q != ST_LINEAR);
wire kill_slot = (state_q == ST_SLOT_KILL);
wire killed = insn_valid_i && kill_slot;
wire live = insn_valid_i && !kill_slot;

// Exceptions suppress every write of the faulting instruction
wire exc_cu = live && is_fp && !fp_usable_i;
wire exc_ri = live && is_align && fp_usable_i && !fp_ps_enabled_i;
wire exc_any = exc_cu || exc_ri;
wire commit = live && !exc_any;
wire recognised = is_align || is_and || is_and_immediate || is_branch;

// Addresses relative to the current instruction
wire [31:0] slot_pc = pc_q + `INSN_STEP;
wire [31:0] link_pc = slot_pc + `INSN_STEP;
wire take = is_beq0 || is_bal || (is_fpbr && fp_taken);
// A branch sitting in a slot is ignored rather than trapped
wire start_branch = commit && is_branch && !in_slot;

// Next program counter and slot state
always @*
begin
	state_d = state_q;
	pc_d = pc_q;
	target_d = target_q;
	if (insn_valid_i)
	begin
		case (state_q)
			ST_LINEAR:
				pc_d = slot_pc;
			ST_SLOT_FALL:
				pc_d = slot_pc;
			ST_SLOT_TAKE:
				pc_d = target_q;
			ST_SLOT_KILL:
				pc_d = slot_pc;
			default:
				pc_d = slot_pc;
		endcase
		state_d = ST_LINEAR;
		if (start_branch)
		begin
			target_d = slot_pc + branch_offset(imm16);
			if (take)
				state_d = ST_SLOT_TAKE;
			else if (is_fpbr && nd_flag)
				state_d = ST_SLOT_KILL;
			else
				state_d = ST_SLOT_FALL;
		end
	end
end

// Register file write ports
reg gpr_we_d;
reg [4:0] gpr_waddr_d;
reg [XLEN-1:0] gpr_wdata_d;
reg fpr_we_d;
reg [4:0] fpr_waddr_d;
reg [FLEN-1:0] fpr_wdata_d;

always @*
begin
	gpr_we_d = 1'b0;
	gpr_waddr_d = gpr_waddr_o;
	gpr_wdata_d = gpr_wdata_o;
	fpr_we_d = 1'b0;
	fpr_waddr_d = fpr_waddr_o;
	fpr_wdata_d = fpr_wdata_o;
	if (commit)
	begin
		if (is_and)
		begin
			gpr_we_d = 1'b1;
			gpr_waddr_d = f_rd;
			gpr_wdata_d = gpr_source_i & gpr_target_i;
		end
		else if (is_and_immediate)
		begin
			gpr_we_d = 1'b1;
			gpr_waddr_d = f_rt;
			gpr_wdata_d = gpr_source_i & {{(XLEN-16){1'b0}}, imm16};
		end
		else if (is_align)
		begin
			fpr_we_d = 1'b1;
			fpr_waddr_d = f_sa;
			fpr_wdata_d = align_res;
		end
	end
	// Link goes with the branch itself, so a slot fault cannot lose it
	if (start_branch && is_bal)
	begin
		gpr_we_d = 1'b1;
		gpr_waddr_d = `LINK_REG;
		gpr_wdata_d = link_pc;
	end
end

// Status pulses for the next cycle
reg delay_slot_d;
reg nullified_d;
reg exc_cu_d;
reg exc_ri_d;
reg decode_error_d;

always @*
begin
	delay_slot_d = insn_valid_i && in_slot;
	nullified_d = killed;
	exc_cu_d = exc_cu;
	exc_ri_d = exc_ri;
	decode_error_d = live && !recognised;
end

// Sequencing registers
always @(posedge clk_i)
begin
	if (reset_i)
	begin
		state_q <= ST_LINEAR;
		pc_q <= `PC_RESET;
		target_q <= 32'h00000000;
		pc_o <= `PC_RESET;
		delay_slot_o <= 1'b0;
		nullified_o <= 1'b0;
	end
	else
	begin
		state_q <= state_d;
		pc_q <= pc_d;
		target_q <= target_d;
		pc_o <= pc_d;
		delay_slot_o <= delay_slot_d;
		nullified_o <= nullified_d;
	end
end

// Integer write port
always @(posedge clk_i)
begin
	if (reset_i)
	begin
		gpr_we_o <= 1'b0;
		gpr_waddr_o <= 5'h00;
		gpr_wdata_o <= {XLEN{1'b0}};
	end
	else
	begin
		gpr_we_o <= gpr_we_d;
		gpr_waddr_o <= gpr_waddr_d;
		gpr_wdata_o <= gpr_wdata_d;
	end
end

// FP write port and exceptions; no FP flag or cause update leaves here
always @(posedge clk_i)
begin
	if (reset_i)
	begin
		fpr_we_o <= 1'b0;
		fpr_waddr_o <= 5'h00;
		fpr_wdata_o <= {FLEN{1'b0}};
		fp_flags_we_o <= 1'b0;
		exc_cop_unusable_o <= 1'b0;
		exc_reserved_o <= 1'b0;
		exc_fp_unimpl_o <= 1'b0;
		decode_error_o <= 1'b0;
	end
	else
	begin
		fpr_we_o <= fpr_we_d;
		fpr_waddr_o <= fpr_waddr_d;
		fpr_wdata_o <= fpr_wdata_d;
		fp_flags_we_o <= 1'b0;
		exc_cop_unusable_o <= exc_cu_d;
		exc_reserved_o <= exc_ri_d;
		// Unimplemented-operation trap is optional and never raised
		exc_fp_unimpl_o <= 1'b0;
		decode_error_o <= decode_error_d;
	end
end

endmodule

// ---- bench/align_logic_branch_exec_chk.sv ----
// Port assertions for the align, AND and branch decoder
`timescale 1ns/100ps
module align_logic_branch_exec_chk
(
	input wire clk_i,
	input wire reset_i,
	input wire insn_valid_i,
	input wire [31:0] insn_i,
	input wire [31:0] gpr_source_i,
	input wire [31:0] gpr_target_i,
	input wire [63:0] fp_source_a_i,
	input wire fp_usable_i,
	input wire fp_ps_enabled_i,
	input wire gpr_we_o,
	input wire [4:0] gpr_waddr_o,
	input wire [31:0] gpr_wdata_o,
	input wire fpr_we_o,
	input wire [63:0] fpr_wdata_o,
	input wire fp_flags_we_o,
	input wire [31:0] pc_o,
	input wire exc_cop_unusable_o
);
	reg kill_q;
	wire [5:0] op = insn_i[31:26];
	wire go = insn_valid_i && !kill_q;
	wire br = insn_valid_i && insn_i[31:16] == 16'h1000;
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (reset_i);
	// Slot of a nullifying branch may be cancelled, so skip it
	always @(posedge clk_i)
		kill_q <= insn_valid_i && insn_i[31:21] == 11'h228 && insn_i[17];
	AST_ALIGN_ZERO: assert property (go && op == 6'h13 && insn_i[5:0] == 6'h1E
		&& fp_usable_i && fp_ps_enabled_i && gpr_source_i[2:0] == 3'h0
		|=> fpr_we_o && fpr_wdata_o == $past(fp_source_a_i)) else $error("align zero bad");
	AST_NO_FLAGS: assert property (insn_valid_i && op == 6'h13 |=> !fp_flags_we_o)
		else $error("align set flags");
	AST_AND: assert property (go && op == 6'h00 && insn_i[10:0] == 11'h024
		|=> gpr_we_o && gpr_wdata_o == $past(gpr_source_i & gpr_target_i)) else $error("and bad");
	AST_AND_IMMEDIATE: assert property (go && op == 6'h0C |=> gpr_waddr_o == $past(insn_i[20:16])
		&& gpr_wdata_o == $past(gpr_source_i & {16'h0000, insn_i[15:0]})) else $error("and_immediate bad");
	AST_LINK: assert property (insn_valid_i && insn_i[31:16] == 16'h0411
		|=> gpr_we_o && gpr_waddr_o == 5'h1F && gpr_wdata_o == $past(pc_o) + 32'h8)
		else $error("link bad");
	AST_PC_STEP: assert property (br |=> pc_o == $past(pc_o) + 32'h4)
		else $error("pc moved early");
	AST_TARGET: assert property (br ##1 insn_valid_i |=> pc_o == $past(pc_o)
		+ {{14{$past(insn_i[15], 2)}}, $past(insn_i[15:0], 2), 2'h0}) else $error("target bad");
	AST_CU: assert property (go && op == 6'h13 && !fp_usable_i
		|=> exc_cop_unusable_o && !fpr_we_o) else $error("no unusable trap");
endmodule
bind align_logic_branch_exec align_logic_branch_exec_chk i_chk (.*);

// ---- bench/test_align_logic_branch_exec.sv ----
// Self-checking bench for the align, AND and branch decoder
`timescale 1ns/100ps
module test_align_logic_branch_exec;
	reg clk_i = 0, reset_i = 1, insn_valid_i = 0, fp_usable_i = 1, fp_ps_enabled_i = 1;
	reg big_endian_i = 0, br = 0, tk = 0, nul = 0;
	reg [31:0] insn_i = 0, gpr_source_i = 0, gpr_target_i = 0, pc = 0, tgt = 0, r;
	reg [31:0] seed = 32'h000014F8;
	reg [63:0] fp_source_a_i = 0, fp_source_b_i = 0;
	reg [7:0] fp_condition_codes_i = 0;
	wire [4:0] gpr_source_sel_o, gpr_target_sel_o, fp_source_a_sel_o, fp_source_b_sel_o;
	wire [4:0] gpr_waddr_o, fpr_waddr_o;
	wire [31:0] gpr_wdata_o, pc_o;
	wire [63:0] fpr_wdata_o;
	wire gpr_we_o, fpr_we_o, fp_flags_we_o, delay_slot_o, nullified_o, exc_cop_unusable_o;
	wire exc_reserved_o, exc_fp_unimpl_o, decode_error_o;
	wire [19:0] sels = {gpr_source_sel_o, gpr_target_sel_o, fp_source_a_sel_o, fp_source_b_sel_o};
	wire [4:0] excs = {exc_cop_unusable_o, exc_reserved_o, exc_fp_unimpl_o, decode_error_o,
		fp_flags_we_o};
	integer n_fail = 0, checked = 0, i, j;
	align_logic_branch_exec i_align_logic_branch_exec
	(
		.clk_i(clk_i),
		.reset_i(reset_i),
		.insn_valid_i(insn_valid_i),
		.insn_i(insn_i),
		.gpr_source_i(gpr_source_i),
		.gpr_target_i(gpr_target_i),
		.fp_source_a_i(fp_source_a_i),
		.fp_source_b_i(fp_source_b_i),
		.fp_condition_codes_i(fp_condition_codes_i),
		.fp_usable_i(fp_usable_i),
		.fp_ps_enabled_i(fp_ps_enabled_i),
		.big_endian_i(big_endian_i),
		.gpr_source_sel_o(gpr_source_sel_o),
		.gpr_target_sel_o(gpr_target_sel_o),
		.fp_source_a_sel_o(fp_source_a_sel_o),
		.fp_source_b_sel_o(fp_source_b_sel_o),
		.gpr_we_o(gpr_we_o),
		.gpr_waddr_o(gpr_waddr_o),
		.gpr_wdata_o(gpr_wdata_o),
		.fpr_we_o(fpr_we_o),
		.fpr_waddr_o(fpr_waddr_o),
		.fpr_wdata_o(fpr_wdata_o),
		.fp_flags_we_o(fp_flags_we_o),
		.pc_o(pc_o),
		.delay_slot_o(delay_slot_o),
		.nullified_o(nullified_o),
		.exc_cop_unusable_o(exc_cop_unusable_o),
		.exc_reserved_o(exc_reserved_o),
		.exc_fp_unimpl_o(exc_fp_unimpl_o),
		.decode_error_o(decode_error_o)
	);
	always #25 clk_i = ~clk_i;
	function [31:0] rnd(input [31:0] s);
		rnd = s ^ (s << 13);
		rnd = rnd ^ (rnd >> 17);
		rnd = rnd ^ (rnd << 5);
	endfunction
	task chk(input [68:0] g, input [68:0] e);
		checked = checked + 1;
		if (g !== e)
		begin
			n_fail = n_fail + 1;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task tally_and_finish;
		if (n_fail == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task issue(input [31:0] w, input [1:0] up);
		reg [63:0] a, b, f;
		reg [31:0] gd, npc;
		reg [5:0] o;
		reg gw, fw, k, s, t;
		begin
			o = w[31:26];
			seed = rnd(seed);
			a = {seed, rnd(~seed)};
			b = {rnd(a[31:0]), seed ^ 32'h0F0F0F0F};
			gpr_source_i = {seed[31:3], seed[2], 2'h0};
			{gpr_target_i, fp_source_a_i, fp_source_b_i} = {b[31:0], a, b};
			{fp_condition_codes_i, big_endian_i} = {a[7:0], b[40]};
			{fp_usable_i, fp_ps_enabled_i, insn_i, insn_valid_i} = {up, w, 1'b1};
			#1 chk(sels, {w[25:11], w[20:16]});
			{k, s, npc} = {nul, br, tk ? tgt : pc + 32'h4};
			br = o == 6'h04 || o == 6'h01 || o == 6'h11;
			t = o != 6'h11 || fp_condition_codes_i[w[20:18]] === w[16];
			{tk, nul, tgt} = {br && t, br && w[17] && !t, pc + 32'h4 + {{14{w[15]}}, w[15:0], 2'h0}};
			gw = (o == 6'h01 || o == 6'h0C || o == 6'h00) && !k;
			fw = o == 6'h13 && up == 2'h3 && !k;
			gd = o == 6'h01 ? pc + 32'h8 : gpr_source_i & (o == 6'h0C ? {16'h0, w[15:0]} : gpr_target_i);
			f = !gpr_source_i[2] ? a : big_endian_i ? {a[31:0], b[63:32]} : {b[31:0], a[63:32]};
			@(negedge clk_i);
			chk(pc_o, npc);
			chk({gpr_we_o, fpr_we_o, delay_slot_o, nullified_o}, {gw, fw, s, k});
			if (gw)
				chk({gpr_waddr_o, gpr_wdata_o}, {o == 6'h01 ? 5'h1F : o == 6'h0C ? w[20:16] : w[15:11], gd});
			if (fw)
				chk({fpr_waddr_o, fpr_wdata_o}, {w[10:6], f});
			chk(excs, {!up[1], up == 2'h2, 3'h0});
			pc = npc;
		end
	endtask
	initial
	begin
		repeat (5) @(negedge clk_i);
		reset_i = 0;
		for (i = 0; i < 40; i = i + 1)
		begin
			seed = rnd(seed);
			r = rnd(~seed);
			// No branch in a slot
			j = (br || i == 39) ? seed % 3 : seed % 6;
			case (j)
				0: issue({6'h00, r[25:11], 11'h024}, 2'h3);
				1: issue({6'h0C, r[25:0]}, 2'h3);
				2: issue({6'h13, r[25:6], 6'h1E}, 2'h3);
				3: issue({16'h1000, r[15:0]}, 2'h3);
				4: issue({16'h0411, r[15:0]}, 2'h3);
				default: issue({11'h228, r[20:0]}, 2'h3);
			endcase
		end
		r = {6'h13, r[25:6], 6'h1E};
		issue(r, 2'h1);
		issue(r, 2'h2);
		tally_and_finish;
	end
	initial
	begin
		#20000;
		n_fail = n_fail + 1;
		tally_and_finish;
	end
endmodule
